// [design/kibc_pkg.sv]
/*
 * Package for the keypad interrupt and brownout control register bank.
 * Holds register offsets, field positions, reset values and the bus struct.
 * Assumes a 32-bit Avalon-MM slave with byte-granular word addresses.
 */
package kibc_pkg;
  // Printed offsets are not byte offsets: each is an index, byte address is index times four
  localparam logic [7:0] IDX_PIN_ENABLE = 8'ha1;
  localparam logic [7:0] IDX_AUX_CTRL = 8'ha2;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'hb0;
  localparam logic [7:0] IDX_IRQ_MASK = 8'hb1;
  localparam int ADDR_W = 10;
  // Aux control field positions
  localparam int BIT_KEYPAD_FLAG = 7;
  localparam int BIT_BROWNOUT_DISABLE = 6;
  localparam int BIT_BROWNOUT_IRQ_SEL = 5;
  localparam int BIT_LOW_POWER_BO = 4;
  localparam int BIT_SOFT_RESET = 3;
  localparam int BIT_THRESH_HI = 2;
  localparam int BIT_THRESH_LO = 1;
  localparam int BIT_BROWNOUT_STATUS = 0;
  // Interrupt status bits
  localparam int EVT_KEYPAD = 0;
  localparam int EVT_BROWNOUT = 1;
  localparam int EVT_W = 2;
  // Threshold codes
  localparam logic [1:0] THR_2V6 = 2'h0;
  localparam logic [1:0] THR_3V8 = 2'h2;
  localparam logic [1:0] THR_4V5 = 2'h3;
  // Timed access unlock bytes and window
  localparam logic [7:0] IDX_TIMED_ACCESS = 8'hc7;
  localparam logic [7:0] TA_KEY1 = 8'haa;
  localparam logic [7:0] TA_KEY2 = 8'h55;
  localparam int TA_WINDOW = 4;
  // Low-power sampling: detector on one sixteenth of the time
  localparam int LP_PERIOD = 16;
  localparam logic [7:0] PIN_ENABLE_RST = 8'h00;
  localparam logic [EVT_W-1:0] MASK_RST = 2'h0;

  typedef struct packed {
    logic read;
    logic write;
    logic [ADDR_W-1:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } kibc_bus_req_s;

  typedef struct packed {
    logic waitrequest;
    logic [31:0] readdata;
  } kibc_bus_rsp_s;

  typedef struct packed {
    logic detectorOn;
    logic [1:0] threshold;
    logic oscEnable;
  } kibc_bo_ctrl_s;
endpackage : kibc_pkg

// [design/kibc_top.sv]
/*
 * Keypad interrupt and brownout control register bank with Avalon-MM slave.
 * Assumes keypad pins and comparator levels are asynchronous; config bits are
 * stable straps; the chip reset network acts on softResetReq and brownoutResetReq.
 */
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/1ps
module kibc_top (
  input wire logic ref_clk, // 250 MHz core clock
  input wire logic resetn, // Async active-low reset
  input wire logic clkEn, // Freezes all state except the reset synchroniser when low
  input wire logic [kibc_pkg::ADDR_W-1:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Byte lanes
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall
  input wire logic [7:0] keypadPins, // Port 0 pin levels
  input wire logic keypadLevelSelect, // Trigger level: 1 high, 0 low
  input wire logic brownoutConfigBit, // Config strap for disable
  input wire logic [1:0] brownoutThresholdConfig, // Config straps for threshold
  input wire logic powerDown, // Core is in power-down
  input wire logic supplyAboveUpper, // Comparator: above upper threshold
  input wire logic supplyBelowLower, // Comparator: below lower threshold
  output kibc_pkg::kibc_bo_ctrl_s boCtrl, // Detector controls
  output logic softResetReq, // One-cycle chip reset pulse
  output logic brownoutResetReq, // Brownout chip reset request
  output logic irq // Level interrupt
);
  logic [1:0] rstSync;
  logic rstn;
  logic [7:0] pinMeta, pinSync;
  logic [1:0] cmpMeta, cmpSync;
  logic [7:0] pinEnable_reg;
  logic keypadFlag_reg, brownoutDisable_reg, irqSel_reg, lowPower_reg, status_reg;
  logic [1:0] threshold_reg;
  logic [kibc_pkg::EVT_W-1:0] evtStatus_reg, evtMask_reg;
  logic [2:0] taWindow_reg;
  logic taStage_reg, taOpen;
  logic [3:0] lpCount_reg;
  logic strapLoad_reg;
  logic [31:0] readData_reg;
  logic readDone_reg;
  logic keypadEvent, brownoutSeen, brownoutEvent, boPrev_reg;
  logic wrAccess;
  logic [7:0] wrIndex, wrByte;

  function automatic logic [7:0] word_index(input logic [kibc_pkg::ADDR_W-1:0] a);
    word_index = a[kibc_pkg::ADDR_W-1:2];
  endfunction : word_index

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rstSync <= 2'h0;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  assign rstn = rstSync[1];

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pinMeta <= 8'h00;
      pinSync <= 8'h00;
      cmpMeta <= 2'h0;
      cmpSync <= 2'h0;
    end else if (clkEn) begin
      pinMeta <= keypadPins;
      pinSync <= pinMeta;
      cmpMeta <= {supplyAboveUpper, supplyBelowLower};
      cmpSync <= cmpMeta;
    end
  end

  assign wrAccess = avs_write && clkEn && avs_byteenable[0];
  assign wrIndex = word_index(avs_address);
  assign wrByte = avs_writedata[7:0];
  assign taOpen = taWindow_reg != 3'h0;

  // Level trigger per enabled pin
  assign keypadEvent = |(pinEnable_reg & (keypadLevelSelect ? pinSync : ~pinSync));

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pinEnable_reg <= kibc_pkg::PIN_ENABLE_RST;
    end else if (clkEn && wrAccess && wrIndex == kibc_pkg::IDX_PIN_ENABLE) begin
      pinEnable_reg <= wrByte;
    end
  end

  // Straps caught on the first enabled edge after release, never under reset
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      strapLoad_reg <= 1'b1;
    end else if (clkEn) begin
      strapLoad_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      brownoutDisable_reg <= 1'b1;
      threshold_reg <= kibc_pkg::THR_2V6;
      irqSel_reg <= 1'b0;
      lowPower_reg <= 1'b0;
    end else if (clkEn) begin
      if (strapLoad_reg) begin
        brownoutDisable_reg <= ~brownoutConfigBit;
        threshold_reg <= ~brownoutThresholdConfig;
      end else if (wrAccess && wrIndex == kibc_pkg::IDX_AUX_CTRL) begin
        brownoutDisable_reg <= wrByte[kibc_pkg::BIT_BROWNOUT_DISABLE];
        irqSel_reg <= wrByte[kibc_pkg::BIT_BROWNOUT_IRQ_SEL];
        lowPower_reg <= wrByte[kibc_pkg::BIT_LOW_POWER_BO];
        threshold_reg <= wrByte[kibc_pkg::BIT_THRESH_HI:kibc_pkg::BIT_THRESH_LO];
      end
    end
  end

  // Flag: hardware sets, software writes zero; set wins
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      keypadFlag_reg <= 1'b0;
    end else if (clkEn) begin
      if (keypadEvent) begin
        keypadFlag_reg <= 1'b1;
      end else if (wrAccess && wrIndex == kibc_pkg::IDX_AUX_CTRL) begin
        keypadFlag_reg <= wrByte[kibc_pkg::BIT_KEYPAD_FLAG];
      end
    end
  end

  // Timed access: two key bytes open a short window
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      taStage_reg <= 1'b0;
      taWindow_reg <= 3'h0;
    end else if (clkEn) begin
      if (wrAccess && wrIndex == kibc_pkg::IDX_TIMED_ACCESS) begin
        taStage_reg <= wrByte == kibc_pkg::TA_KEY1;
        if (taStage_reg && wrByte == kibc_pkg::TA_KEY2) begin
          taWindow_reg <= 3'(kibc_pkg::TA_WINDOW);
        end
      end else if (taOpen) begin
        taWindow_reg <= taWindow_reg - 3'h1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      softResetReq <= 1'b0;
    end else if (clkEn) begin
      softResetReq <= wrAccess && wrIndex == kibc_pkg::IDX_AUX_CTRL && taOpen
        && wrByte[kibc_pkg::BIT_SOFT_RESET];
    end
  end

  // Detector duty: one sample slot in sixteen while powered down with low-power mode set
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      lpCount_reg <= 4'h0;
    end else if (clkEn) begin
      lpCount_reg <= lpCount_reg + 4'h1;
    end
  end

  always_comb begin
    // Upper bit clear means the lowest level, whatever the lower bit holds
    boCtrl.threshold = (threshold_reg == kibc_pkg::THR_3V8 || threshold_reg == kibc_pkg::THR_4V5)
      ? threshold_reg : kibc_pkg::THR_2V6;
    boCtrl.oscEnable = !brownoutDisable_reg && lowPower_reg && powerDown;
    boCtrl.detectorOn = !brownoutDisable_reg
      && (!(lowPower_reg && powerDown) || lpCount_reg == 4'h0);
  end

  // Status holds between thresholds (hysteresis)
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      status_reg <= 1'b0;
    end else if (clkEn && boCtrl.detectorOn) begin
      if (cmpSync[0]) begin
        status_reg <= 1'b1;
      end else if (cmpSync[1]) begin
        status_reg <= 1'b0;
      end
    end
  end

  assign brownoutSeen = status_reg && !brownoutDisable_reg;
  assign brownoutResetReq = brownoutSeen && !irqSel_reg;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      boPrev_reg <= 1'b0;
    end else if (clkEn) begin
      boPrev_reg <= brownoutSeen;
    end
  end
  assign brownoutEvent = brownoutSeen && !boPrev_reg && irqSel_reg;

  // Sticky events, write-one-to-clear, set wins
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      evtStatus_reg <= '0;
    end else if (clkEn) begin
      if (wrAccess && wrIndex == kibc_pkg::IDX_IRQ_STATUS) begin
        evtStatus_reg <= (evtStatus_reg & ~wrByte[kibc_pkg::EVT_W-1:0]) | {brownoutEvent, keypadEvent};
      end else begin
        evtStatus_reg <= evtStatus_reg | {brownoutEvent, keypadEvent};
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      evtMask_reg <= kibc_pkg::MASK_RST;
    end else if (clkEn && wrAccess && wrIndex == kibc_pkg::IDX_IRQ_MASK) begin
      evtMask_reg <= wrByte[kibc_pkg::EVT_W-1:0];
    end
  end
  assign irq = |(evtStatus_reg & evtMask_reg);

  // Reads take one registered cycle; writes complete at once
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      readData_reg <= 32'h0000_0000;
      readDone_reg <= 1'b0;
    end else if (clkEn) begin
      readDone_reg <= avs_read && !readDone_reg;
      if (avs_read && !readDone_reg) begin
        case (word_index(avs_address))
          kibc_pkg::IDX_PIN_ENABLE: readData_reg <= {24'h000000, pinEnable_reg};
          kibc_pkg::IDX_AUX_CTRL: readData_reg <= {24'h000000, keypadFlag_reg, brownoutDisable_reg,
            irqSel_reg, lowPower_reg, 1'b0, threshold_reg, status_reg};
          kibc_pkg::IDX_IRQ_STATUS: readData_reg <= {30'h00000000, evtStatus_reg};
          kibc_pkg::IDX_IRQ_MASK: readData_reg <= {30'h00000000, evtMask_reg};
          default: readData_reg <= 32'h0000_0000;
        endcase
      end
    end
  end
  assign avs_readdata = readData_reg;
  assign avs_waitrequest = avs_read && !readDone_reg;

  a_flag_sets: assert property (@(posedge ref_clk) disable iff (!rstn)
    clkEn && keypadEvent |=> keypadFlag_reg)
    else $error("keypad flag not set by enabled pin");
  a_flag_stays: assert property (@(posedge ref_clk) disable iff (!rstn)
    keypadFlag_reg && !(wrAccess && wrIndex == kibc_pkg::IDX_AUX_CTRL) |=> keypadFlag_reg)
    else $error("keypad flag cleared without a write");
  a_pin_masked: assert property (@(posedge ref_clk) disable iff (!rstn)
    pinEnable_reg == 8'h00 |-> !keypadEvent)
    else $error("disabled pins raised keypad event");
  a_detector_off: assert property (@(posedge ref_clk) disable iff (!rstn)
    brownoutDisable_reg |-> !boCtrl.detectorOn && !brownoutResetReq)
    else $error("detector active while disabled");
  a_strap_load: assert property (@(posedge ref_clk) disable iff (!rstn)
    strapLoad_reg && clkEn |=> brownoutDisable_reg == !$past(brownoutConfigBit))
    else $error("disable bit missed its strap");
  a_thresh_strap: assert property (@(posedge ref_clk) disable iff (!rstn)
    strapLoad_reg && clkEn |=> threshold_reg == ~$past(brownoutThresholdConfig))
    else $error("threshold missed its strap");
  a_irq_no_reset: assert property (@(posedge ref_clk) disable iff (!rstn)
    irqSel_reg |-> !brownoutResetReq)
    else $error("reset requested in interrupt mode");
  a_bo_reset: assert property (@(posedge ref_clk) disable iff (!rstn)
    !brownoutDisable_reg && !irqSel_reg && status_reg |-> brownoutResetReq)
    else $error("brownout reset not requested");
  a_soft_reset_locked: assert property (@(posedge ref_clk) disable iff (!rstn)
    clkEn && !taOpen |=> !softResetReq)
    else $error("soft reset without unlock");
  a_soft_reset_fires: assert property (@(posedge ref_clk) disable iff (!rstn)
    taOpen && wrAccess && wrIndex == kibc_pkg::IDX_AUX_CTRL && wrByte[kibc_pkg::BIT_SOFT_RESET]
      |=> softResetReq ##1 !softResetReq)
    else $error("soft reset pulse wrong");
  a_lp_duty: assert property (@(posedge ref_clk) disable iff (!rstn)
    clkEn && boCtrl.detectorOn && lowPower_reg && powerDown
      |=> !boCtrl.detectorOn || !(lowPower_reg && powerDown))
    else $error("low-power detector on outside slot");
  a_status_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
    clkEn && boCtrl.detectorOn && cmpSync[0] |=> status_reg)
    else $error("status not set below lower threshold");
  a_thresh_out: assert property (@(posedge ref_clk) disable iff (!rstn)
    boCtrl.threshold[1] == threshold_reg[1] && (threshold_reg[1] || boCtrl.threshold == kibc_pkg::THR_2V6))
    else $error("threshold output differs");
endmodule : kibc_top

// [testbench/kibc_keypad_model.sv]
/*
 * Keypad switch model on port 0: a pressed key drives its pin to the active level.
 * Assumes the bench supplies the press pattern and the trigger level.
 */
`timescale 1ns/1ps
module kibc_keypad_model (
  input wire logic ref_clk, // Core clock
  input wire logic levelSel, // Active level of a press
  input wire logic [7:0] pressMask, // Keys held down
  output logic [7:0] pins // Port 0 levels
);
  // Idle pins sit at the inactive level; just after a level change they look like a press until the pins catch up
  logic [7:0] pinsReg = 8'hff;
  assign pins = pinsReg;
  always @(posedge ref_clk) begin
    pinsReg <= pressMask ^ {8{~levelSel}};
  end
endmodule : kibc_keypad_model

// [testbench/tb_top.sv]
/*
 * Self-checking bench for kibc_top: reset straps, thresholds, keypad, brownout, soft reset.
 * Assumes the design package and the keypad model are compiled first.
 */
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin testsRun++; if ((gt) !== (ex)) begin errCount++; $display("wrong value %s exp %h got %h", nm, ex, gt); end end
module tb_top;
  localparam logic [7:0] PEN = kibc_pkg::IDX_PIN_ENABLE;
  localparam logic [7:0] AUX = kibc_pkg::IDX_AUX_CTRL;
  localparam logic [7:0] STA = kibc_pkg::IDX_IRQ_STATUS;
  localparam logic [7:0] MSK = kibc_pkg::IDX_IRQ_MASK;
  localparam logic [7:0] TA = kibc_pkg::IDX_TIMED_ACCESS;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic [kibc_pkg::ADDR_W-1:0] avsAddress = '0;
  logic avsRead = 1'b0;
  logic avsWrite = 1'b0;
  logic [31:0] avsWritedata = '0;
  logic [3:0] avsByteenable = 4'h1;
  logic clkEn = 1'b1;
  logic [31:0] avsReaddata;
  logic avsWaitrequest;
  logic [7:0] keypadPins;
  logic [7:0] pressMask = 8'h00;
  logic levelSel = 1'b0;
  logic cfgBit = 1'b0;
  logic [1:0] cfgThr = 2'h0;
  logic powerDown = 1'b0;
  logic aboveUp = 1'b1;
  logic belowLo = 1'b0;
  kibc_pkg::kibc_bo_ctrl_s boCtrl;
  logic softResetReq;
  logic brownoutResetReq;
  logic irq;
  int errCount = 0;
  int testsRun = 0;
  int srCount = 0;
  logic [31:0] seed = 32'h11;
  logic [7:0] rd;
  logic [7:0] en;
  logic [7:0] cnt;
  always #2 ref_clk = ~ref_clk;
  always @(negedge ref_clk) if (softResetReq === 1'b1) srCount++;
  kibc_top i_dut (.ref_clk(ref_clk), .resetn(resetn), .clkEn(clkEn), .avs_address(avsAddress),
    .avs_read(avsRead), .avs_write(avsWrite), .avs_writedata(avsWritedata), .avs_byteenable(avsByteenable),
    .avs_readdata(avsReaddata), .avs_waitrequest(avsWaitrequest), .keypadPins(keypadPins),
    .keypadLevelSelect(levelSel), .brownoutConfigBit(cfgBit), .brownoutThresholdConfig(cfgThr),
    .powerDown(powerDown), .supplyAboveUpper(aboveUp), .supplyBelowLower(belowLo), .boCtrl(boCtrl),
    .softResetReq(softResetReq), .brownoutResetReq(brownoutResetReq), .irq(irq));
  kibc_keypad_model i_keys (.ref_clk(ref_clk), .levelSel(levelSel), .pressMask(pressMask), .pins(keypadPins));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs
  // Any code with a clear upper bit means the lowest threshold
  function automatic logic [1:0] expThr(input logic [1:0] f);
    return f[1] ? f : kibc_pkg::THR_2V6;
  endfunction : expThr
  task automatic complete_run;
    $display("checks %0d mismatches %0d", testsRun, errCount);
    if (errCount == 0 && testsRun > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : complete_run
  // Request stands until the rising edge that samples waitrequest low; read data taken there
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    avsAddress <= {idx, 2'h0};
    avsWrite <= wr;
    avsRead <= ~wr;
    avsWritedata <= {24'h0, wd};
    do begin
      @(posedge ref_clk);
      n++;
    end while (avsWaitrequest !== 1'b0 && n < 50);
    if (avsWaitrequest !== 1'b0) begin
      errCount++;
      complete_run();
    end
    rd = avsReaddata[7:0];
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
    @(posedge ref_clk);
  endtask : xfer
  task automatic do_reset(input logic c, input logic [1:0] t);
    resetn <= 1'b0;
    cfgBit <= c;
    cfgThr <= t;
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge ref_clk);
  endtask : do_reset
  initial begin
    for (int i = 0; i < 2; i++) begin
      seed = xs(seed);
      do_reset(seed[0], seed[2:1]);
      xfer(0, AUX, 8'h00);
      `CHK("aux reset", {1'b0, ~seed[0], 3'h0, ~seed[2:1], 1'b0}, rd)
      `CHK("detector on", seed[0], boCtrl.detectorOn)
      `CHK("threshold reset", expThr(~seed[2:1]), boCtrl.threshold)
      xfer(0, PEN, 8'h00);
      `CHK("pin enable reset", kibc_pkg::PIN_ENABLE_RST, rd)
    end
    $display("test reset done");
    for (int f = 0; f < 4; f++) begin
      xfer(1, AUX, {5'h0, f[1:0], 1'b0});
      xfer(0, AUX, 8'h00);
      `CHK("threshold field", {5'h0, f[1:0], 1'b0}, rd)
      `CHK("threshold out", expThr(f[1:0]), boCtrl.threshold)
    end
    xfer(1, 8'h10, 8'hff);
    xfer(0, 8'h10, 8'h00);
    `CHK("unmapped", 8'h00, rd)
    avsByteenable <= 4'h0;
    xfer(1, PEN, 8'hff);
    avsByteenable <= 4'h1;
    xfer(0, PEN, 8'h00);
    `CHK("lane off write", 8'h00, rd)
    clkEn <= 1'b0;
    xfer(1, PEN, 8'h5a);
    clkEn <= 1'b1;
    xfer(0, PEN, 8'h00);
    `CHK("frozen write", 8'h00, rd)
    $display("test threshold done");
    for (int lv = 0; lv < 2; lv++) begin
      levelSel <= lv[0];
      // Pins lag the level select by the model and synchroniser: let a false trigger pass first
      repeat (8) @(posedge ref_clk);
      seed = xs(seed);
      en = (seed[7:0] | 8'h01) & 8'h7f;
      xfer(1, PEN, en);
      xfer(1, AUX, 8'h00);
      xfer(1, STA, 8'h03);
      xfer(1, MSK, 8'h01);
      pressMask <= ~en;
      repeat (8) @(posedge ref_clk);
      xfer(0, AUX, 8'h00);
      `CHK("masked pins", 1'b0, rd[7])
      pressMask <= en & (~en + 8'h01);
      repeat (8) @(posedge ref_clk);
      pressMask <= 8'h00;
      repeat (8) @(posedge ref_clk);
      xfer(0, AUX, 8'h00);
      `CHK("flag held", 1'b1, rd[7])
      `CHK("irq keypad", 1'b1, irq)
      xfer(1, MSK, 8'h00);
      `CHK("irq masked", 1'b0, irq)
      xfer(1, MSK, 8'h01);
      xfer(1, STA, 8'h01);
      xfer(0, STA, 8'h00);
      `CHK("status cleared", 8'h00, rd)
      `CHK("irq cleared", 1'b0, irq)
      xfer(1, AUX, 8'h00);
      xfer(0, AUX, 8'h00);
      `CHK("flag cleared", 1'b0, rd[7])
    end
    $display("test keypad done");
    xfer(1, MSK, 8'h02);
    xfer(1, AUX, 8'h20);
    aboveUp <= 1'b0;
    belowLo <= 1'b1;
    repeat (8) @(posedge ref_clk);
    xfer(1, AUX, 8'h20);
    xfer(0, AUX, 8'h00);
    `CHK("status low", 8'h21, rd)
    `CHK("no reset in irq mode", 1'b0, brownoutResetReq)
    `CHK("brownout irq", 1'b1, irq)
    xfer(1, AUX, 8'h00);
    `CHK("brownout reset", 1'b1, brownoutResetReq)
    xfer(1, AUX, 8'h40);
    `CHK("disabled no reset", 1'b0, brownoutResetReq)
    `CHK("detector off", 1'b0, boCtrl.detectorOn)
    xfer(1, AUX, 8'h00);
    aboveUp <= 1'b1;
    belowLo <= 1'b0;
    repeat (8) @(posedge ref_clk);
    xfer(0, AUX, 8'h00);
    `CHK("status high", 8'h00, rd)
    xfer(1, STA, 8'h03);
    $display("test brownout done");
    powerDown <= 1'b1;
    for (int lp = 0; lp < 2; lp++) begin
      xfer(1, AUX, lp[0] ? 8'h10 : 8'h00);
      cnt = 8'h00;
      repeat (64) begin
        @(posedge ref_clk);
        cnt = cnt + {7'h0, boCtrl.detectorOn};
      end
      `CHK("detector duty", lp[0] ? 8'h04 : 8'h40, cnt)
      `CHK("osc enable", lp[0], boCtrl.oscEnable)
    end
    powerDown <= 1'b0;
    $display("test low power done");
    srCount = 0;
    xfer(1, AUX, 8'h08);
    xfer(1, TA, kibc_pkg::TA_KEY2);
    xfer(1, TA, kibc_pkg::TA_KEY1);
    xfer(1, AUX, 8'h08);
    repeat (8) @(posedge ref_clk);
    `CHK("locked soft reset", 0, srCount)
    xfer(1, TA, kibc_pkg::TA_KEY1);
    xfer(1, TA, kibc_pkg::TA_KEY2);
    xfer(1, AUX, 8'h08);
    repeat (4) @(posedge ref_clk);
    `CHK("soft reset pulse", 1, srCount)
    $display("test soft reset done");
    complete_run();
  end
endmodule : tb_top
